// [logic/tocmp_pkg.sv]
/*
 * Package for the timer output compare block: mode codes, action codes,
 * reset values and the packed structs carried between the ports.
 * Assumes a 16-bit counter and an 8-bit processor data bus outside.
 */
package tocmp_pkg;
    localparam int unsigned TOCMP_CNT_W = 16;
    localparam logic [15:0] TOCMP_CMP_RST = 16'h0000;
    localparam logic [15:0] TOCMP_CNT_MAX = 16'hFFFF;
    localparam logic [3:0] TOCMP_MODE_NORMAL = 4'h0;
    localparam logic [3:0] TOCMP_MODE_CTC_CMPA = 4'h4;
    localparam logic [3:0] TOCMP_MODE_CTC_CAP = 4'hC;
    localparam logic [3:0] TOCMP_MODE_FAST_CAP = 4'hE;
    localparam logic [3:0] TOCMP_MODE_FAST_CMPA = 4'hF;
    localparam logic [1:0] TOCMP_ACT_NONE = 2'h0;
    localparam logic [1:0] TOCMP_ACT_TOGGLE = 2'h1;
    localparam logic [1:0] TOCMP_ACT_CLEAR = 2'h2;
    localparam logic [1:0] TOCMP_ACT_SET = 2'h3;
    localparam logic TOCMP_OUT_RST = 1'b0;

    // One processor write toward a compare channel
    typedef struct packed {
        logic wr_high;
        logic wr_low;
        logic [7:0] data;
    } tocmp_cpu_wr_s;

    // Position of the counter within its count sequence
    typedef struct packed {
        logic [15:0] value;
        logic at_ceiling;
        logic at_floor;
        logic counting_down;
        logic tick;
    } tocmp_cnt_s;

    typedef enum logic [1:0] {
        TOCMP_KIND_NONPWM,
        TOCMP_KIND_FAST,
        TOCMP_KIND_DUAL
    } tocmp_kind_e;
endpackage : tocmp_pkg

// [logic/tocmp_unit.sv]
/*
 * Two output compare channels (A and B) of a 16-bit timer: comparators,
 * double-buffered compare values, flags and the waveform output bits.
 * Assumes the counter, its sequencing and capture live outside; the counter
 * state arrives each cycle on cnt_in with a one-cycle timer tick.
 */
// Notes on behaviour
// - Each channel compares counter and compare value every cycle.
// - Match at a timer tick sets compare_flag on the next clock.
// - Enabled set flag requests interrupt; service acknowledge clears it.
// - Writing one to flag clears it; zero leaves it.
// - Channel A compare value serves as ceiling in selecting modes.
// - PWM modes double buffer; normal and clear-on-match write directly.
// - Buffered value loads only at ceiling or floor.
// - Reads return buffer or register directly, no latch.
// - High byte latched first; low write moves both in one cycle.
// - Force strobe in non-PWM acts as match, no flag.
// - Counter write blocks all matches at the next tick.
// - Counter written equal ceiling loses ceiling match; counts to max.
// - Output state survives mode changes; reset clears it.
// - Action select unbuffered; applies at next match or force.
// - Nonzero action overrides port value; direction stays with port.
// - Action zero leaves output unchanged on match.
// - Action select does not touch input capture.
// - Only mode shapes counting; action picks output behaviour.
// - Mode 0 normal; modes 4 and 12 clear-on-match.
// - Clear-on-match action 1 toggles output each match.
// - Fast PWM: non-inverting clears on match, sets at floor.
`timescale 1ns/100ps
module tocmp_unit
    import tocmp_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire tocmp_cnt_s cnt_in,
    input wire logic cnt_write_in,
    input wire logic [3:0] waveform_mode_sel_in,
    input wire tocmp_cpu_wr_s cpu_wr_a_in,
    input wire tocmp_cpu_wr_s cpu_wr_b_in,
    input wire logic [1:0] output_action_sel_a_in,
    input wire logic [1:0] output_action_sel_b_in,
    input wire logic [1:0] force_compare_strobe_in,
    input wire logic [1:0] compare_irq_enable_in,
    input wire logic [1:0] flag_clear_in,
    input wire logic [1:0] irq_ack_in,
    input wire logic [1:0] port_value_in,
    input wire logic [1:0] pin_direction_in,
    output logic [15:0] compare_value_a_out,
    output logic [15:0] compare_value_b_out,
    output logic [15:0] count_ceiling_a_out,
    output logic [1:0] compare_flag_out,
    output logic [1:0] irq_request_out,
    output logic [1:0] compare_match_out,
    output logic [1:0] compare_output_out,
    output logic [1:0] pin_value_out,
    output logic [1:0] pin_oe_out
);
    // Mode class decode, used by both channels and the buffer path
    function automatic tocmp_kind_e mode_kind(input logic [3:0] m);
        unique case (m)
            TOCMP_MODE_NORMAL, TOCMP_MODE_CTC_CMPA, TOCMP_MODE_CTC_CAP,
            4'hD: mode_kind = TOCMP_KIND_NONPWM;
            4'h5, 4'h6, 4'h7, TOCMP_MODE_FAST_CAP,
            TOCMP_MODE_FAST_CMPA: mode_kind = TOCMP_KIND_FAST;
            default: mode_kind = TOCMP_KIND_DUAL;
        endcase
    endfunction : mode_kind

    logic [7:0] hi_latch_ff, nxt_hi_latch;
    logic block_ff, nxt_block;
    logic [15:0] cmp_ff [2];
    logic [15:0] buf_ff [2];
    logic [15:0] nxt_cmp [2];
    logic [15:0] nxt_buf [2];
    logic [1:0] flag_ff, nxt_flag;
    logic [1:0] match_ff, nxt_match;
    logic [1:0] oc_ff, nxt_oc;
    logic [1:0] pin_ff, nxt_pin;
    logic [1:0] oe_ff, nxt_oe;
    logic [1:0] irq_ff, nxt_irq;
    tocmp_kind_e kind;
    tocmp_cpu_wr_s wr [2];
    logic [1:0] act [2];

    assign kind = mode_kind(waveform_mode_sel_in);
    assign wr[0] = cpu_wr_a_in;
    assign wr[1] = cpu_wr_b_in;
    assign act[0] = output_action_sel_a_in;
    assign act[1] = output_action_sel_b_in;

    // Shared high-byte latch: both channels write through it
    always_comb begin
        nxt_hi_latch = hi_latch_ff;
        if (wr[0].wr_high) begin
            nxt_hi_latch = wr[0].data;
        end else if (wr[1].wr_high) begin
            nxt_hi_latch = wr[1].data;
        end
        // Held until the next tick; a stopped timer keeps the block armed
        nxt_block = block_ff;
        if (cnt_write_in) begin
            nxt_block = 1'b1;
        end else if (cnt_in.tick) begin
            nxt_block = 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            hi_latch_ff <= 8'h00;
            block_ff <= 1'b0;
        end else begin
            hi_latch_ff <= nxt_hi_latch;
            block_ff <= nxt_block;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            logic eq;
            logic hit;
            logic pwm_act;
            logic [15:0] wval;
            assign eq = (cnt_in.value == cmp_ff[ch]);
            // Counter writing to the ceiling value loses this match too
            assign hit = eq && cnt_in.tick && !block_ff && !cnt_write_in;
            assign wval = {hi_latch_ff, wr[ch].data};
            assign pwm_act = act[ch][1];

            always_comb begin
                nxt_cmp[ch] = cmp_ff[ch];
                nxt_buf[ch] = buf_ff[ch];
                nxt_flag[ch] = flag_ff[ch];
                nxt_oc[ch] = oc_ff[ch];
                if (kind == TOCMP_KIND_NONPWM) begin
                    if (wr[ch].wr_low) begin
                        nxt_cmp[ch] = wval;
                        nxt_buf[ch] = wval;
                    end
                end else begin
                    if (wr[ch].wr_low) begin
                        nxt_buf[ch] = wval;
                    end
                    if (cnt_in.tick && (cnt_in.at_ceiling || cnt_in.at_floor)) begin
                        nxt_cmp[ch] = nxt_buf[ch];
                    end
                end
                if (flag_clear_in[ch] || irq_ack_in[ch]) begin
                    nxt_flag[ch] = 1'b0;
                end
                if (hit) begin
                    nxt_flag[ch] = 1'b1;
                end
                unique case (kind)
                    TOCMP_KIND_NONPWM: begin
                        if (hit || force_compare_strobe_in[ch]) begin
                            unique case (act[ch])
                                TOCMP_ACT_TOGGLE: nxt_oc[ch] = ~oc_ff[ch];
                                TOCMP_ACT_CLEAR: nxt_oc[ch] = 1'b0;
                                TOCMP_ACT_SET: nxt_oc[ch] = 1'b1;
                                default: nxt_oc[ch] = oc_ff[ch];
                            endcase
                        end
                    end
                    TOCMP_KIND_FAST: begin
                        if (pwm_act) begin
                            if (hit) begin
                                nxt_oc[ch] = act[ch][0];
                            end else if (cnt_in.tick && cnt_in.at_floor) begin
                                nxt_oc[ch] = ~act[ch][0];
                            end
                        end
                    end
                    TOCMP_KIND_DUAL: begin
                        // Up-slope clears for non-inverting, down-slope sets
                        if (pwm_act && hit) begin
                            nxt_oc[ch] = act[ch][0] ^ cnt_in.counting_down;
                        end
                    end
                endcase
                nxt_match[ch] = hit;
                nxt_irq[ch] = nxt_flag[ch] && compare_irq_enable_in[ch];
                // Override only when an action is selected
                nxt_pin[ch] = (act[ch] != TOCMP_ACT_NONE) ? nxt_oc[ch]
                                                          : port_value_in[ch];
                nxt_oe[ch] = pin_direction_in[ch];
            end

            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    cmp_ff[ch] <= TOCMP_CMP_RST;
                    buf_ff[ch] <= TOCMP_CMP_RST;
                    flag_ff[ch] <= 1'b0;
                    oc_ff[ch] <= TOCMP_OUT_RST;
                end else begin
                    cmp_ff[ch] <= nxt_cmp[ch];
                    buf_ff[ch] <= nxt_buf[ch];
                    flag_ff[ch] <= nxt_flag[ch];
                    oc_ff[ch] <= nxt_oc[ch];
                end
            end
        end
    endgenerate

    logic [15:0] nxt_rd_a, nxt_rd_b;
    logic [15:0] rd_a_ff, rd_b_ff, ceil_ff;
    always_comb begin
        // Software sees the buffer when buffering, else the live register
        nxt_rd_a = (kind == TOCMP_KIND_NONPWM) ? nxt_cmp[0] : nxt_buf[0];
        nxt_rd_b = (kind == TOCMP_KIND_NONPWM) ? nxt_cmp[1] : nxt_buf[1];
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            match_ff <= 2'b00;
            irq_ff <= 2'b00;
            pin_ff <= 2'b00;
            oe_ff <= 2'b00;
            rd_a_ff <= TOCMP_CMP_RST;
            rd_b_ff <= TOCMP_CMP_RST;
            ceil_ff <= TOCMP_CMP_RST;
        end else begin
            match_ff <= nxt_match;
            irq_ff <= nxt_irq;
            pin_ff <= nxt_pin;
            oe_ff <= nxt_oe;
            rd_a_ff <= nxt_rd_a;
            rd_b_ff <= nxt_rd_b;
            ceil_ff <= nxt_cmp[0];
        end
    end

    assign compare_value_a_out = rd_a_ff;
    assign compare_value_b_out = rd_b_ff;
    assign count_ceiling_a_out = ceil_ff;
    assign compare_flag_out = flag_ff;
    assign irq_request_out = irq_ff;
    assign compare_match_out = match_ff;
    assign compare_output_out = oc_ff;
    assign pin_value_out = pin_ff;
    assign pin_oe_out = oe_ff;

    sequence s_hit_a;
        cnt_in.tick && !block_ff && !cnt_write_in && (cnt_in.value == cmp_ff[0]);
    endsequence

    // First tick after a counter write, when it comes one or two cycles after the write
    sequence s_wr_then_tick;
        (cnt_write_in ##1 cnt_in.tick) or (cnt_write_in ##1 !cnt_in.tick ##1 cnt_in.tick);
    endsequence

    a_flag_after_match: assert property (@(posedge clock_in) disable iff (rst_in)
        s_hit_a |=> compare_flag_out[0])
        else $error("flag A not set after match");
    a_match_pulse_a: assert property (@(posedge clock_in) disable iff (rst_in)
        s_hit_a |=> compare_match_out[0])
        else $error("match A not reported");
    a_block_after_wr: assert property (@(posedge clock_in) disable iff (rst_in)
        s_wr_then_tick |=> !compare_match_out[0] && !compare_match_out[1])
        else $error("match not blocked after counter write");
    a_flag_clear_sw: assert property (@(posedge clock_in) disable iff (rst_in)
        flag_clear_in[1] && !nxt_match[1] |=> !compare_flag_out[1])
        else $error("flag B not cleared by write");
    a_irq_request: assert property (@(posedge clock_in) disable iff (rst_in)
        compare_flag_out[0] && compare_irq_enable_in[0] && !irq_ack_in[0]
        && !flag_clear_in[0] |=> irq_request_out[0])
        else $error("interrupt A not requested");
    a_force_no_flag: assert property (@(posedge clock_in) disable iff (rst_in)
        force_compare_strobe_in[0] && !nxt_match[0] && !compare_flag_out[0]
        |=> !compare_flag_out[0])
        else $error("force set flag A");
    a_hold_action0: assert property (@(posedge clock_in) disable iff (rst_in)
        output_action_sel_b_in == TOCMP_ACT_NONE |=> $stable(compare_output_out[1]))
        else $error("output B moved with no action");
    a_direct_write: assert property (@(posedge clock_in) disable iff (rst_in)
        kind == TOCMP_KIND_NONPWM && cpu_wr_a_in.wr_low
        |=> cmp_ff[0] == {$past(hi_latch_ff), $past(cpu_wr_a_in.data)})
        else $error("direct write A wrong");
    a_toggle_ctc: assert property (@(posedge clock_in) disable iff (rst_in)
        (waveform_mode_sel_in == TOCMP_MODE_CTC_CMPA
        && output_action_sel_a_in == TOCMP_ACT_TOGGLE) and s_hit_a
        |=> compare_output_out[0] != $past(compare_output_out[0]))
        else $error("output A did not toggle");
    // Force is refused in PWM modes; without a tick nothing may move the output
    a_pwm_no_force: assert property (@(posedge clock_in) disable iff (rst_in)
        kind != TOCMP_KIND_NONPWM && force_compare_strobe_in[0] && !cnt_in.tick
        |=> $stable(compare_output_out[0]))
        else $error("force moved output A in PWM");
    a_pin_override: assert property (@(posedge clock_in) disable iff (rst_in)
        output_action_sel_a_in != TOCMP_ACT_NONE |=> pin_value_out[0] == compare_output_out[0])
        else $error("pin A not driven by output state");
    a_pin_port: assert property (@(posedge clock_in) disable iff (rst_in)
        output_action_sel_a_in == TOCMP_ACT_NONE |=> pin_value_out[0] == $past(port_value_in[0]))
        else $error("pin A not driven by port value");
    a_oe_follow: assert property (@(posedge clock_in) disable iff (rst_in)
        1'b1 |=> pin_oe_out == $past(pin_direction_in))
        else $error("pin enable does not follow direction");
    a_floor_set_b: assert property (@(posedge clock_in) disable iff (rst_in)
        kind == TOCMP_KIND_FAST && output_action_sel_b_in == TOCMP_ACT_CLEAR
        && cnt_in.tick && cnt_in.at_floor && !nxt_match[1] |=> compare_output_out[1])
        else $error("output B not set at floor");
    a_match_clear_b: assert property (@(posedge clock_in) disable iff (rst_in)
        kind == TOCMP_KIND_FAST && output_action_sel_b_in == TOCMP_ACT_CLEAR
        && nxt_match[1] |=> !compare_output_out[1])
        else $error("output B not cleared on match");
endmodule : tocmp_unit

// [verification/tocmp_host_model.sv]
/*
 * Far-side model of the compare channels: a single-slope up counter with
 * a one-cycle tick, plus the processor's byte writes toward both channels.
 * Assumes the bench holds run_in low while it loads the counter.
 */
`timescale 1ns/100ps
module tocmp_host_model
    import tocmp_pkg::*;
(
    input wire logic clock_in,
    input wire logic run_in,
    input wire logic [15:0] ceiling_in,
    output tocmp_cnt_s cnt_out,
    output logic cnt_write_out,
    output tocmp_cpu_wr_s cpu_wr_a_out,
    output tocmp_cpu_wr_s cpu_wr_b_out
);
    logic [15:0] value_r = 16'h0000;
    logic tick_r = 1'b0;

    initial begin
        cnt_write_out = 1'b0;
        cpu_wr_a_out = '0;
        cpu_wr_b_out = '0;
    end

    assign cnt_out = '{value_r, value_r == ceiling_in, value_r == 16'h0000, 1'b0, tick_r};

    // Steps at the end of each tick cycle, so the first tick sees a loaded value
    always @(negedge clock_in) begin
        if (tick_r) begin
            value_r <= (value_r == ceiling_in) ? 16'h0000 : value_r + 16'h0001;
        end
        tick_r <= run_in;
    end

    task automatic load_count(input logic [15:0] v);
        @(negedge clock_in);
        value_r <= v;
        cnt_write_out <= 1'b1;
        @(negedge clock_in);
        cnt_write_out <= 1'b0;
    endtask : load_count

    task automatic put(input logic ch_b, input tocmp_cpu_wr_s w);
        if (ch_b) begin
            cpu_wr_b_out <= w;
        end else begin
            cpu_wr_a_out <= w;
        end
    endtask : put

    // Idle bus shows the inverse of the last byte, never a stale copy
    task automatic write16(input logic ch_b, input logic [15:0] v);
        @(negedge clock_in);
        put(ch_b, '{1'b1, 1'b0, v[15:8]});
        @(negedge clock_in);
        put(ch_b, '{1'b0, 1'b1, v[7:0]});
        @(negedge clock_in);
        put(ch_b, '{1'b0, 1'b0, ~v[7:0]});
    endtask : write16
endmodule : tocmp_host_model

// [verification/tocmp_unit_tb_top.sv]
/*
 * Self-checking bench for the two compare channels: forced actions from a
 * table, then writes, matches, blocking, clear-on-match and fast PWM.
 * Assumes the host model supplies counter and byte writes.
 */
`timescale 1ns/100ps
module tocmp_unit_tb_top
    import tocmp_pkg::*;
;
    typedef struct packed {
        logic [3:0] mode;
        logic [1:0] act;
        logic [1:0] exp;
    } tocmp_row_s;

    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic run = 1'b0;
    logic [3:0] mode = 4'h0;
    logic [1:0] act_a = 2'h0, act_b = 2'h0, frc = 2'h0, irq_en = 2'h0;
    logic [1:0] flag_clr = 2'h0, ack = 2'h0, port_val = 2'h0, pin_dir = 2'h3;
    logic [15:0] ceiling, cva, cvb, ceil_a, max_seen, toggles;
    logic [1:0] flag, irq, match, cout, pin_val, pin_oe, seen, prev;
    logic cnt_write;
    tocmp_cnt_s cnt;
    tocmp_cpu_wr_s wr_a, wr_b;
    int error_cnt = 0;
    int checks = 0;
    tocmp_row_s rows [0:7] = '{
        '{4'h0, 2'h3, 2'h3}, '{4'h0, 2'h0, 2'h3}, '{4'h4, 2'h2, 2'h0},
        '{4'hC, 2'h1, 2'h3}, '{4'h0, 2'h1, 2'h0}, '{4'hF, 2'h3, 2'h0},
        '{4'h1, 2'h2, 2'h0}, '{4'h0, 2'h3, 2'h3}};

    always #12.5 clock_in = ~clock_in;
    assign ceiling = (mode == 4'h4 || mode == 4'hF) ? ceil_a : TOCMP_CNT_MAX;

    tocmp_host_model tocmp_host_model_i (.clock_in(clock_in), .run_in(run),
        .ceiling_in(ceiling), .cnt_out(cnt), .cnt_write_out(cnt_write),
        .cpu_wr_a_out(wr_a), .cpu_wr_b_out(wr_b));

    tocmp_unit tocmp_unit_i (.clock_in(clock_in), .rst_in(rst_in), .cnt_in(cnt),
        .cnt_write_in(cnt_write), .waveform_mode_sel_in(mode), .cpu_wr_a_in(wr_a),
        .cpu_wr_b_in(wr_b), .output_action_sel_a_in(act_a), .output_action_sel_b_in(act_b),
        .force_compare_strobe_in(frc), .compare_irq_enable_in(irq_en),
        .flag_clear_in(flag_clr), .irq_ack_in(ack), .port_value_in(port_val),
        .pin_direction_in(pin_dir), .compare_value_a_out(cva), .compare_value_b_out(cvb),
        .count_ceiling_a_out(ceil_a), .compare_flag_out(flag), .irq_request_out(irq),
        .compare_match_out(match), .compare_output_out(cout), .pin_value_out(pin_val),
        .pin_oe_out(pin_oe));

    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk16

    task automatic chk2(input string what, input logic [1:0] exp, input logic [1:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : chk2

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    // Which: 0 flag clear, 1 interrupt service, 2 force strobe
    task automatic pulse(input int which, input logic [1:0] v);
        @(negedge clock_in);
        if (which == 0) flag_clr <= v;
        else if (which == 1) ack <= v;
        else frc <= v;
        @(negedge clock_in);
        {flag_clr, ack, frc} <= '0;
        repeat (3) @(negedge clock_in);
    endtask : pulse

    // Runs n ticks from a freshly written count, gathering outputs seen
    task automatic run_from(input logic [15:0] start, input int n);
        tocmp_host_model_i.load_count(start);
        run <= 1'b1;
        {seen, toggles, max_seen} = '0;
        prev = cout;
        repeat (n) begin
            @(negedge clock_in);
            seen |= match;
            toggles += 16'(cout[0] != prev[0]);
            prev = cout;
            if (cnt.value > max_seen) max_seen = cnt.value;
        end
        run <= 1'b0;
        repeat (3) @(negedge clock_in);
    endtask : run_from

    initial begin
        repeat (2000) @(posedge clock_in);
        error_cnt++;
        give_verdict();
    end

    initial begin
        repeat (5) @(negedge clock_in);
        rst_in <= 1'b0;
        @(negedge clock_in);
        chk2("compare_output", 2'b00, cout);
        chk2("compare_flag", 2'b00, flag);
        foreach (rows[i]) begin
            @(negedge clock_in);
            // Port and direction vary per row so the override is visible
            {mode, act_a, act_b, port_val, pin_dir} <= {rows[i].mode, rows[i].act,
                rows[i].act, ~rows[i].exp, rows[i].exp ^ 2'b01};
            pulse(2, 2'b11);
            chk2("compare_output", rows[i].exp, cout);
            chk2("pin_value", (rows[i].act != 2'h0) ? rows[i].exp : port_val, pin_val);
            chk2("pin_oe", pin_dir, pin_oe);
            chk2("compare_flag", 2'b00, flag);
        end
        {act_a, act_b, irq_en} <= {2'h0, 2'h0, 2'b11};
        tocmp_host_model_i.write16(1'b0, 16'h1234);
        chk16("compare_value_a", 16'h1234, cva);
        chk16("count_ceiling_a", 16'h1234, ceil_a);
        tocmp_host_model_i.write16(1'b1, 16'h0010);
        chk16("compare_value_b", 16'h0010, cvb);
        run_from(16'h000C, 8);
        chk2("compare_match", 2'b10, seen);
        chk2("compare_flag", 2'b10, flag);
        chk2("irq_request", 2'b10, irq);
        pulse(0, 2'b01);
        chk2("compare_flag", 2'b10, flag);
        pulse(0, 2'b10);
        chk2("compare_flag", 2'b00, flag);
        run_from(16'h0010, 8);
        chk2("compare_flag", 2'b00, flag);
        run_from(16'h000C, 8);
        pulse(1, 2'b10);
        chk2("compare_flag", 2'b00, flag);
        {mode, act_a} <= {TOCMP_MODE_CTC_CMPA, TOCMP_ACT_TOGGLE};
        tocmp_host_model_i.write16(1'b0, 16'h0005);
        run_from(16'h0000, 60);
        chk16("count_max", 16'h0005, max_seen);
        chk2("toggles", 2'b01, {1'b0, toggles inside {16'd9, 16'd10}});
        {mode, act_a, act_b} <= {TOCMP_MODE_FAST_CMPA, TOCMP_ACT_NONE, TOCMP_ACT_CLEAR};
        tocmp_host_model_i.write16(1'b0, 16'h0003);
        chk16("compare_value_a", 16'h0003, cva);
        chk16("count_ceiling_a", 16'h0005, ceil_a);
        tocmp_host_model_i.write16(1'b1, 16'h0002);
        tocmp_host_model_i.load_count(16'h0000);
        run <= 1'b1;
        seen = 2'b00;
        repeat (20) begin
            @(negedge clock_in);
            seen |= {~cout[1], cout[1]};
        end
        run <= 1'b0;
        chk16("count_ceiling_a", 16'h0003, ceil_a);
        chk2("pwm_levels", 2'b11, seen);
        give_verdict();
    end
endmodule : tocmp_unit_tb_top
